// ===== rtl/fclr_top.v
// Front clock routing, trigger connector direction and status indicators,
// with an AXI4-Lite register slave. Assumes all inputs synchronous to mclk.
//
// Functional notes
// - Front clock input steers to backplane reference, PLL, distribution or logic.
// - Front clock output source is oven, backplane, synthesizer or distribution.
// - Six single-ended trigger pins, each input or output.
// - Differential mode pairs connectors; each pair input or output, never both.
// - Host indicator dark until driver initialises, then green.
// - Every host access shows amber on host indicator for 50 ms while no over-temperature or hardware failure is present.
// - Over-temperature blinks the host indicator red.
// - Hardware failure holds the host indicator solid red.
// - Lock indicator off when PLL unused and no error.
// - Lock indicator green while PLL in use and locked.
// - Software may force lock indicator amber; errors override it.
// - Lock indicator solid red while PLL tries to lock.
`timescale 1ns/1ns
`default_nettype none
`include "fclr_regs.vh"

module fclr_top
#(
    parameter [`FCLR_TIMER_W-1:0] FLASH_CYCLES =
        `FCLR_FLASH_MS * `FCLR_NS_PER_MS / `FCLR_CLK_PERIOD_NS,
    parameter [`FCLR_TIMER_W-1:0] BLINK_CYCLES =
        `FCLR_BLINK_MS * `FCLR_NS_PER_MS / `FCLR_CLK_PERIOD_NS
)
(
    input wire mclk,
    input wire reset_n,
    input wire [`FCLR_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`FCLR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire overTemp,
    input wire hwError,
    input wire pllInUse,
    input wire pllLocked,
    output reg [3:0] frontClockInputRoute,
    output reg [1:0] frontClockOutputSel,
    input wire [5:0] trigDrive,
    output wire [5:0] trigSense,
    input wire [5:0] trigPinIn,
    output wire [5:0] trigPinOut,
    output wire [5:0] trigPinOe,
    output reg hostLedRed,
    output reg hostLedGreen,
    output reg lockLedRed,
    output reg lockLedGreen,
    output reg irq
);

    // --------------------
    // Reset release
    // --------------------
    reg [1:0] rstPipe;
    wire rstSync_n;

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rstPipe <= 2'b00;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSync_n = rstPipe[1];

    // --------------------
    // Registers
    // --------------------
    reg [1:0] ctrl;
    reg [5:0] route;
    reg [13:0] trigCfg;
    reg [`FCLR_EV_W-1:0] irqStat;
    reg [`FCLR_EV_W-1:0] irqMask;
    reg overTempPrev;
    reg hwErrorPrev;
    reg lockedPrev;

    // --------------------
    // AXI4-Lite slave
    // --------------------
    reg awHeld;
    reg wHeld;
    reg [`FCLR_ADDR_W-1:0] awAddr;
    reg [31:0] wData;
    reg [3:0] wStrb;
    wire awFire;
    wire wFire;
    wire arFire;
    wire doWrite;
    wire readIrqStat;
    wire lockNow;
    wire [`FCLR_EV_W-1:0] events;
    reg [31:0] readValue;
    reg readOk;
    reg [31:0] byteMask;

    assign awFire = s_axi_awvalid & s_axi_awready;
    assign wFire = s_axi_wvalid & s_axi_wready;
    assign arFire = s_axi_arvalid & s_axi_arready;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
    assign readIrqStat = arFire && (s_axi_araddr == `FCLR_OFF_IRQ_STAT);

    always @*
    begin
        byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
    end

    always @*
    begin
        readOk = 1'b1;
        readValue = 32'h00000000;
        case (s_axi_araddr)
            `FCLR_OFF_CTRL: readValue = {30'h00000000, ctrl};
            `FCLR_OFF_ROUTE: readValue = {26'h0000000, route};
            `FCLR_OFF_TRIG: readValue = {18'h00000, trigCfg};
            `FCLR_OFF_STATUS: readValue = {20'h00000, hostLedRed, hostLedGreen,
                                           lockLedRed, lockLedGreen, 4'h0,
                                           pllLocked, pllInUse, hwError, overTemp};
            `FCLR_OFF_IRQ_STAT: readValue = {28'h0000000, irqStat};
            `FCLR_OFF_IRQ_MASK: readValue = {28'h0000000, irqMask};
            default: readOk = 1'b0;
        endcase
    end

    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FCLR_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `FCLR_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= {`FCLR_ADDR_W{1'b0}};
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            ctrl <= `FCLR_CTRL_RST;
            route <= `FCLR_ROUTE_RST;
            trigCfg <= `FCLR_TRIG_RST;
            irqMask <= {`FCLR_EV_W{1'b0}};
        end
        else
        begin
            // Address and data are taken independently, in either order.
            s_axi_awready <= ~awHeld & ~awFire & ~s_axi_bvalid;
            s_axi_wready <= ~wHeld & ~wFire & ~s_axi_bvalid;
            if (awFire)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (wFire)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `FCLR_RESP_OKAY;
                case (awAddr)
                    `FCLR_OFF_CTRL:
                        ctrl <= (ctrl & ~byteMask[1:0]) | (wData[1:0] & byteMask[1:0]);
                    `FCLR_OFF_ROUTE:
                        route <= (route & ~byteMask[5:0]) | (wData[5:0] & byteMask[5:0]);
                    `FCLR_OFF_TRIG:
                        trigCfg <= (trigCfg & ~byteMask[13:0]) | (wData[13:0] & byteMask[13:0]);
                    `FCLR_OFF_IRQ_MASK:
                        irqMask <= (irqMask & ~byteMask[3:0]) | (wData[3:0] & byteMask[3:0]);
                    `FCLR_OFF_STATUS, `FCLR_OFF_IRQ_STAT:
                        s_axi_bresp <= `FCLR_RESP_OKAY;
                    default:
                        s_axi_bresp <= `FCLR_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            // Reads answer on the same edge that takes the address.
            s_axi_arready <= ~arFire & ~s_axi_rvalid;
            if (arFire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readValue;
                s_axi_rresp <= readOk ? `FCLR_RESP_OKAY : `FCLR_RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // --------------------
    // Event flags and interrupt
    // --------------------
    assign lockNow = pllInUse & pllLocked;
    assign events = {lockedPrev & ~lockNow, ~lockedPrev & lockNow,
                     hwError & ~hwErrorPrev, overTemp & ~overTempPrev};

    // A new event in the cycle of the clearing read stays set.
    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            irqStat <= {`FCLR_EV_W{1'b0}};
            overTempPrev <= 1'b0;
            hwErrorPrev <= 1'b0;
            lockedPrev <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            overTempPrev <= overTemp;
            hwErrorPrev <= hwError;
            lockedPrev <= lockNow;
            irqStat <= (readIrqStat ? {`FCLR_EV_W{1'b0}} : irqStat) | events;
            irq <= |(((readIrqStat ? {`FCLR_EV_W{1'b0}} : irqStat) | events) & irqMask);
        end
    end

    // --------------------
    // Front clock routing
    // --------------------
    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            frontClockInputRoute <= 4'h0;
            frontClockOutputSel <= `FCLR_OUT_FROM_OVEN;
        end
        else
        begin
            // One destination at a time; disabled routes leave the input idle.
            frontClockInputRoute <= route[`FCLR_ROUTE_IN_EN] ?
                (4'h1 << route[`FCLR_ROUTE_IN_HI:`FCLR_ROUTE_IN_LO]) : 4'h0;
            frontClockOutputSel <= route[`FCLR_ROUTE_OUT_HI:`FCLR_ROUTE_OUT_LO];
        end
    end

    // --------------------
    // Trigger connectors
    // --------------------
    // In differential mode connectors 2k and 2k+1 form pair k; the odd
    // connector carries the complement. One direction bit per pair means a
    // pair can never drive and receive at once.
    genvar pin;
    generate
        for (pin = 0; pin < 6; pin = pin + 1)
        begin : gPin
            wire diff;
            wire en;
            wire val;
            assign diff = trigCfg[`FCLR_TRIG_DIFF];
            assign en = diff ? trigCfg[`FCLR_TRIG_PAIR_LO + pin / 2]
                             : trigCfg[`FCLR_TRIG_PIN_LO + pin];
            assign val = diff ? (trigDrive[pin / 2] ^ (pin % 2 == 1)) : trigDrive[pin];
            fclr_pin_cell uCell
            (
                .mclk(mclk),
                .rstSync_n(rstSync_n),
                .pinIn(trigPinIn[pin]),
                .driveEn(en),
                .driveValue(val),
                .pinOut(trigPinOut[pin]),
                .pinOe(trigPinOe[pin]),
                .sense(trigSense[pin])
            );
        end
    endgenerate

    // --------------------
    // Host access indicator
    // --------------------
    wire flashBusy;
    wire blinkBusy;
    wire hostAccess;
    wire blinkLoad;
    reg blinkPhase;

    assign hostAccess = doWrite | arFire;
    assign blinkLoad = overTemp & ~blinkBusy;

    fclr_timer #(.WIDTH(`FCLR_TIMER_W)) uFlash
    (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .load(hostAccess),
        .loadValue(FLASH_CYCLES),
        .busy(flashBusy)
    );

    fclr_timer #(.WIDTH(`FCLR_TIMER_W)) uBlink
    (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .load(blinkLoad),
        .loadValue(BLINK_CYCLES),
        .busy(blinkBusy)
    );

    localparam [4:0] HOST_OFF = 5'b00001;
    localparam [4:0] HOST_GREEN = 5'b00010;
    localparam [4:0] HOST_AMBER = 5'b00100;
    localparam [4:0] HOST_BLINK = 5'b01000;
    localparam [4:0] HOST_ERROR = 5'b10000;
    reg [4:0] hostState;
    reg [4:0] next_hostState;

    always @*
    begin
        if (hwError)
            next_hostState = HOST_ERROR;
        else if (overTemp)
            next_hostState = HOST_BLINK;
        else if (flashBusy | hostAccess)
            next_hostState = HOST_AMBER;
        else if (ctrl[`FCLR_CTRL_INIT])
            next_hostState = HOST_GREEN;
        else
            next_hostState = HOST_OFF;
    end

    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            hostState <= HOST_OFF;
            blinkPhase <= 1'b0;
            hostLedRed <= 1'b0;
            hostLedGreen <= 1'b0;
        end
        else
        begin
            hostState <= next_hostState;
            // Each expiry of the period flips the lamp while the heat lasts.
            if (!overTemp)
                blinkPhase <= 1'b0;
            else if (blinkLoad)
                blinkPhase <= ~blinkPhase;
            case (next_hostState)
                HOST_ERROR:
                begin
                    hostLedRed <= 1'b1;
                    hostLedGreen <= 1'b0;
                end
                HOST_BLINK:
                begin
                    hostLedRed <= blinkLoad ? ~blinkPhase : blinkPhase;
                    hostLedGreen <= 1'b0;
                end
                HOST_AMBER:
                begin
                    hostLedRed <= 1'b1;
                    hostLedGreen <= 1'b1;
                end
                HOST_GREEN:
                begin
                    hostLedRed <= 1'b0;
                    hostLedGreen <= 1'b1;
                end
                default:
                begin
                    hostLedRed <= 1'b0;
                    hostLedGreen <= 1'b0;
                end
            endcase
        end
    end

    // --------------------
    // Lock status indicator
    // --------------------
    // A hardware error or a lock attempt in progress wins over the
    // software amber, so identification never hides a fault.
    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            lockLedRed <= 1'b0;
            lockLedGreen <= 1'b0;
        end
        else if (hwError | (pllInUse & ~pllLocked))
        begin
            lockLedRed <= 1'b1;
            lockLedGreen <= 1'b0;
        end
        else if (ctrl[`FCLR_CTRL_AMBER])
        begin
            lockLedRed <= 1'b1;
            lockLedGreen <= 1'b1;
        end
        else
        begin
            lockLedRed <= 1'b0;
            lockLedGreen <= lockNow;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/fclr_regs.vh
// Constants of the front clock routing and status indicator block.
// Included by every design file of the block; holds definitions only.
`ifndef FCLR_REGS_VH
`define FCLR_REGS_VH

// --------------------
// Register byte offsets
// --------------------
`define FCLR_ADDR_W 8
`define FCLR_OFF_CTRL 8'h00
`define FCLR_OFF_ROUTE 8'h04
`define FCLR_OFF_TRIG 8'h08
`define FCLR_OFF_STATUS 8'h0c
`define FCLR_OFF_IRQ_STAT 8'h10
`define FCLR_OFF_IRQ_MASK 8'h14

// --------------------
// Field positions
// --------------------
`define FCLR_CTRL_INIT 0
`define FCLR_CTRL_AMBER 1
`define FCLR_ROUTE_IN_LO 0
`define FCLR_ROUTE_IN_HI 1
`define FCLR_ROUTE_IN_EN 2
`define FCLR_ROUTE_OUT_LO 4
`define FCLR_ROUTE_OUT_HI 5
`define FCLR_TRIG_DIFF 0
`define FCLR_TRIG_PAIR_LO 1
`define FCLR_TRIG_PAIR_HI 3
`define FCLR_TRIG_PIN_LO 8
`define FCLR_TRIG_PIN_HI 13
`define FCLR_EV_OVERTEMP 0
`define FCLR_EV_HWERR 1
`define FCLR_EV_LOCKED 2
`define FCLR_EV_UNLOCKED 3
`define FCLR_EV_W 4

// --------------------
// Reset values and encodings
// --------------------
`define FCLR_CTRL_RST 2'h0
`define FCLR_ROUTE_RST 6'h00
`define FCLR_TRIG_RST 14'h0000
`define FCLR_IN_TO_BACKPLANE 2'h0
`define FCLR_IN_TO_PLL 2'h1
`define FCLR_IN_TO_DISTRIB 2'h2
`define FCLR_IN_TO_LOGIC 2'h3
`define FCLR_OUT_FROM_OVEN 2'h0
`define FCLR_OUT_FROM_BACKPLANE 2'h1
`define FCLR_OUT_FROM_SYNTH 2'h2
`define FCLR_OUT_FROM_DISTRIB 2'h3
`define FCLR_RESP_OKAY 2'h0
`define FCLR_RESP_SLVERR 2'h2

// --------------------
// Timing
// --------------------
`define FCLR_CLK_PERIOD_NS 4
`define FCLR_FLASH_MS 50
`define FCLR_BLINK_MS 250
`define FCLR_NS_PER_MS 1000000
`define FCLR_TIMER_W 26

`endif

// ===== rtl/fclr_timer.v
// Retriggerable down-counter: busy while the loaded count runs out.
// Assumes a synchronous active-low reset from the top module.
`timescale 1ns/1ns
`default_nettype none
`include "fclr_regs.vh"

module fclr_timer
#(
    parameter WIDTH = `FCLR_TIMER_W
)
(
    input wire mclk,
    input wire rstSync_n,
    input wire load,
    input wire [WIDTH-1:0] loadValue,
    output reg busy
);

    reg [WIDTH-1:0] count;

    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            count <= {WIDTH{1'b0}};
            busy <= 1'b0;
        end
        else if (load)
        begin
            count <= loadValue;
            busy <= 1'b1;
        end
        else if (count != {WIDTH{1'b0}})
        begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            busy <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else
        begin
            busy <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/fclr_pin_cell.v
// One front-panel trigger connector: registered drive, enable and capture.
// Assumes pin input synchronous to mclk and a reset released by the top.
`timescale 1ns/1ns
`default_nettype none
`include "fclr_regs.vh"

module fclr_pin_cell
(
    input wire mclk,
    input wire rstSync_n,
    input wire pinIn,
    input wire driveEn,
    input wire driveValue,
    output reg pinOut,
    output reg pinOe,
    output reg sense
);

    // Capture reads zero while the cell drives, so a connector never
    // reports its own output as a received trigger.
    always @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
            sense <= 1'b0;
        end
        else
        begin
            pinOut <= driveEn & driveValue;
            pinOe <= driveEn;
            sense <= ~driveEn & pinIn;
        end
    end

endmodule
`default_nettype wire

// ===== verification/fclr_checker_sva.sv
// Checker of the front clock routing block; sees only fclr_top ports.
// Assumes the bind hands on the top's blink half period.
`timescale 1ns/1ns
`default_nettype none
module fclr_checker #(parameter BLINK_CYCLES = 8)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic overTemp,
    input wire logic hwError,
    input wire logic pllInUse,
    input wire logic pllLocked,
    input wire logic [3:0] frontClockInputRoute,
    input wire logic [5:0] trigSense,
    input wire logic [5:0] trigPinOe,
    input wire logic hostLedRed,
    input wire logic hostLedGreen,
    input wire logic lockLedRed,
    input wire logic lockLedGreen
);
    logic [1:0] upCnt;
    logic [7:0] sameCnt;
    wire live = upCnt == 2'h3;
    // Outputs trail the synchronised reset by a few edges.
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            upCnt <= 2'h0;
        else if (!live)
            upCnt <= upCnt + 2'h1;
    end
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sameCnt <= 8'h00;
        else if (!overTemp || hwError || hostLedRed != $past(hostLedRed))
            sameCnt <= 8'h00;
        else
            sameCnt <= sameCnt + 8'h01;
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence quiet_read;
        live && s_axi_arvalid && s_axi_arready && !hwError && !overTemp
            ##1 (!hwError && !overTemp) [*2];
    endsequence
    hw_error_red_a: assert property (live && hwError |=> hostLedRed && !hostLedGreen)
        else $error("host not red on error");
    blink_period_a: assert property (sameCnt <= BLINK_CYCLES + 2)
        else $error("blink stalled");
    flash_amber_a: assert property (quiet_read |-> hostLedRed && hostLedGreen)
        else $error("no flash after read");
    lock_error_red_a: assert property (live && (hwError || pllInUse && !pllLocked)
        |=> lockLedRed && !lockLedGreen)
        else $error("lock not red");
    lock_green_a: assert property (live && pllInUse && pllLocked && !hwError |=> lockLedGreen)
        else $error("lock not green");
    lock_dark_a: assert property (live && !pllInUse && !hwError |=> lockLedRed == lockLedGreen)
        else $error("lock lit unused");
    route_onehot_a: assert property ($onehot0(frontClockInputRoute))
        else $error("input routed twice");
    sense_masked_a: assert property ((trigSense & trigPinOe) == 6'h00)
        else $error("driving pin sensed");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp not held");
    cover property (live && hwError && overTemp);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (live && pllInUse && !pllLocked && !hwError);
endmodule
`default_nettype wire

// ===== verification/fclr_far_model.sv
// Cabled instruments on the six front trigger connectors.
// Assumes the bench chooses which connectors an instrument drives.
`timescale 1ns/1ns
`default_nettype none
module fclr_far_model
(
    input wire logic mclk,
    input wire logic [5:0] trigPinOut,
    input wire logic [5:0] trigPinOe,
    input wire logic [5:0] extValue,
    input wire logic [5:0] extEn,
    output logic [5:0] trigPinIn
);
    logic [5:0] floatPat = 6'h15;
    // An undriven connector has no pull, so it wanders.
    always @(posedge mclk)
        floatPat <= ~floatPat;
    assign trigPinIn = (trigPinOe & trigPinOut) | (~trigPinOe & extEn & extValue)
        | (~trigPinOe & ~extEn & floatPat);
endmodule
`default_nettype wire

// ===== verification/front_clock_route_and_status_leds_tb.sv
// Self-checking bench of the front clock routing and status indicator block.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "fclr_regs.vh"
module front_clock_route_and_status_leds_tb;
    localparam FL = 20;
    localparam BL = 8;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic overTemp = 1'h0, hwError = 1'h0, pllInUse = 1'h0, pllLocked = 1'h0;
    logic [5:0] trigDrive = 6'h00, extValue = 6'h00, extEn = 6'h00;
    logic [13:0] corner [3] = '{14'h3f00, 14'h000f, 14'h0001};
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, frontClockOutputSel;
    wire [31:0] s_axi_rdata;
    wire [3:0] frontClockInputRoute;
    wire [5:0] trigSense, trigPinIn, trigPinOut, trigPinOe;
    wire hostLedRed, hostLedGreen, lockLedRed, lockLedGreen;
    int err_total = 0;
    int cmp_count = 0;
    fclr_top #(.FLASH_CYCLES(FL), .BLINK_CYCLES(BL)) DUT (.*);
    fclr_far_model far (.*);
    initial forever #2 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bound(input int n);
        if (n >= 200)
        begin
            chk("handshake", 0, 1);
            wrap_up();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'h0;
        bound(n);
        chk("bresp", s_axi_bresp, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'h0;
        bound(n);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", s_axi_rresp, er);
    endtask
    // Returns pin enables above pin levels; unused levels are masked off.
    function automatic logic [11:0] trig_exp(input logic [13:0] c, input logic [5:0] d);
        logic [5:0] oe, o;
        oe = c[13:8];
        o = d;
        if (c[0])
            for (int k = 0; k < 3; k++)
            begin
                oe[2*k] = c[1+k];
                oe[2*k+1] = c[1+k];
                o[2*k] = d[k];
                o[2*k+1] = ~d[k];
            end
        return {oe, o & oe};
    endfunction
    // Argument is hwError, in use, locked, amber; result is red above green.
    function automatic logic [1:0] lock_exp(input logic [3:0] s);
        if (s[3] || (s[2] && !s[1]))
            return 2'h2;
        if (s[0])
            return 2'h3;
        return {1'h0, s[2] & s[1]};
    endfunction

    // --------------------
    // Scenarios
    // --------------------
    initial
    begin
        logic [31:0] v;
        logic [11:0] e;
        int hi;
        void'($urandom(42));
        tick(3);
        reset_n <= 1'h1;
        tick(4);
        chk("leds", {hostLedRed, hostLedGreen, lockLedRed, lockLedGreen}, 0);
        rdc(`FCLR_OFF_ROUTE, 0, `FCLR_RESP_OKAY);
        rdc(`FCLR_OFF_TRIG, 0, `FCLR_RESP_OKAY);
        $display("done: reset");
        wr(`FCLR_OFF_CTRL, 32'h1, `FCLR_RESP_OKAY);
        tick(2);
        chk("host amber", {hostLedRed, hostLedGreen}, 2'h3);
        tick(FL);
        chk("host green", {hostLedRed, hostLedGreen}, 2'h1);
        rdc(`FCLR_OFF_CTRL, 32'h1, `FCLR_RESP_OKAY);
        tick(FL - 4);
        rdc(`FCLR_OFF_CTRL, 32'h1, `FCLR_RESP_OKAY);
        tick(8);
        chk("host retrigger", {hostLedRed, hostLedGreen}, 2'h3);
        $display("done: host indicator");
        for (int i = 0; i < 32; i++)
        begin
            v = ((i >> 3) << 4) | (i & 7);
            wr(`FCLR_OFF_ROUTE, v, `FCLR_RESP_OKAY);
            tick(2);
            chk("input route", frontClockInputRoute, i[2] ? 4'h1 << i[1:0] : 4'h0);
            chk("output source", frontClockOutputSel, i[4:3]);
        end
        $display("done: routing");
        for (int i = 0; i < 12; i++)
        begin
            v = (i < 3) ? {18'h0, corner[i]} : ($urandom & 32'h3f0f);
            trigDrive <= 6'($urandom);
            extValue <= 6'($urandom);
            extEn <= 6'($urandom);
            wr(`FCLR_OFF_TRIG, v, `FCLR_RESP_OKAY);
            tick(2);
            e = trig_exp(v[13:0], trigDrive);
            chk("pin enable", trigPinOe, e[11:6]);
            chk("pin level", trigPinOut & trigPinOe, e[5:0]);
            chk("pin sense", trigSense & extEn & ~e[11:6], extValue & extEn & ~e[11:6]);
        end
        $display("done: triggers");
        for (int i = 0; i < 16; i++)
        begin
            {hwError, pllInUse, pllLocked} <= i[3:1];
            wr(`FCLR_OFF_CTRL, {30'h0, i[0], 1'h1}, `FCLR_RESP_OKAY);
            tick(2);
            chk("lock led", {lockLedRed, lockLedGreen}, lock_exp(i[3:0]));
        end
        $display("done: lock indicator");
        {hwError, pllInUse, pllLocked} <= 3'h0;
        tick(3);
        rdc(`FCLR_OFF_IRQ_STAT, 32'he, `FCLR_RESP_OKAY);
        wr(`FCLR_OFF_IRQ_MASK, 32'h1, `FCLR_RESP_OKAY);
        overTemp <= 1'h1;
        tick(3);
        chk("irq raised", irq, 1'h1);
        hi = 0;
        repeat (2 * BL + 2)
        begin
            @(posedge mclk);
            hi += hostLedRed;
        end
        chk("blink duty", hi, BL + 1);
        rdc(`FCLR_OFF_IRQ_STAT, 32'h1, `FCLR_RESP_OKAY);
        tick(2);
        chk("irq cleared", irq, 1'h0);
        hwError <= 1'h1;
        rdc(`FCLR_OFF_CTRL, 32'h3, `FCLR_RESP_OKAY);
        tick(2);
        chk("host red", {hostLedRed, hostLedGreen}, 2'h2);
        chk("irq masked", irq, 1'h0);
        rdc(`FCLR_OFF_IRQ_STAT, 32'h2, `FCLR_RESP_OKAY);
        {overTemp, hwError} <= 2'h0;
        $display("done: errors and interrupts");
        wr(8'h40, 32'hffffffff, `FCLR_RESP_SLVERR);
        rdc(8'h40, 32'h0, `FCLR_RESP_SLVERR);
        rdc(`FCLR_OFF_CTRL, 32'h3, `FCLR_RESP_OKAY);
        $display("done: unmapped");
        wrap_up();
    end
endmodule
bind fclr_top fclr_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk_i (.*);
`default_nettype wire
